/* File: verilog/pvc_pkg.sv */
// Package for the PI voltage compensator: number formats, gains and the sample and result stream structs.
// Assumes one 100 MHz clock and a per-unit Q1.15 error sample once per switching period.
package pvc_pkg;
  // ==========================================================================
  // Number formats
  // ==========================================================================
  localparam int ERR_W = 16;
  localparam int ERR_FRAC = 15;
  localparam int KP_W = 16;
  localparam int KP_FRAC = 10;
  localparam int KI_W = 16;
  localparam int KI_FRAC = 13;
  localparam int ACC_W = 40;
  localparam int OUT_W = 16;
  localparam int OUT_FRAC = 15;
  // ==========================================================================
  // Gains and timing
  // ==========================================================================
  // 18.5 in Q6.10 and 2.074 in Q3.13 (rounded to the nearest code).
  localparam logic signed [KP_W-1:0] KP_RESET = 16'sh4A00;
  localparam logic signed [KI_W-1:0] KI_RESET = 16'sh425E;
  localparam int CLK_HZ = 100_000_000;
  localparam int FSW_HZ = 72_800;
  // Shortest gap between samples that is not an overrun, rounded down to whole cycles.
  localparam int PERIOD_CYCLES = CLK_HZ / FSW_HZ;
  localparam int FIFO_DEPTH = 8;
  // ==========================================================================
  // Carried types
  // ==========================================================================
  typedef struct packed {
    logic signed [ERR_W-1:0] err;
  } pvc_sample_s;
  typedef struct packed {
    logic signed [OUT_W-1:0] ctrl;
    logic sat;
  } pvc_result_s;
  typedef enum logic [1:0] {
    PVC_IDLE = 2'b00,
    PVC_PROP = 2'b01,
    PVC_INT1 = 2'b11,
    PVC_INT2 = 2'b10
  } pvc_state_e;
endpackage

/* File: verilog/pvc_fifo.sv */
// Holds no logic: the result FIFO module sits beside the compensator that it serves.
// Assumes the compensator's own design file is always read with the package.

/* File: verilog/pvc_pi_voltage_compensator.sv */
// Discrete PI compensator for the output-voltage loop, one update per error sample.
// Assumes the sampler offers one error per switching period; the reference stage drains results.
//
// Behaviour
// - Proportional term is gain kp times present error, kept apart from integral.
// - Integral adds ki*Ts/2 times present error and times previous error each step.
// - Output is proportional term plus the updated integral of the same step.
// - Exactly one update per accepted sample, sample interval equals switching period.
// - Proportional gain is signed Q6.10, nominally 18.5, range plus or minus 32.
// - Integral coefficient is signed Q3.13, nominally 2.074, range plus or minus 4.
// - One multiply, two multiply-accumulates, one addition per update.
// - Gains chosen for 45 degree margin, 10 dB gain margin, 3.5 kHz crossover.
module pvc_pi_voltage_compensator #(
  parameter logic signed [15:0] KP = pvc_pkg::KP_RESET,
  parameter logic signed [15:0] KI = pvc_pkg::KI_RESET
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire pvc_pkg::pvc_sample_s sample,
  input wire logic sample_valid,
  output logic sample_ready,
  output pvc_pkg::pvc_result_s compensator_output,
  output logic compensator_output_valid,
  input wire logic compensator_output_ready,
  output logic update_overrun
);
  localparam int AW = pvc_pkg::ACC_W;
  localparam int SH_P = pvc_pkg::KP_FRAC + pvc_pkg::ERR_FRAC - pvc_pkg::OUT_FRAC;
  localparam int SH_I = pvc_pkg::KI_FRAC;
  localparam int CW = $clog2(pvc_pkg::PERIOD_CYCLES + 1);
  localparam logic signed [AW-1:0] OUT_MAX = AW'(32767);
  localparam logic signed [AW-1:0] OUT_MIN = -AW'(32768);
  // ==========================================================================
  // Datapath state
  // ==========================================================================
  pvc_pkg::pvc_state_e state, next_state;
  logic signed [AW-1:0] acc_p, next_acc_p;
  logic signed [AW-1:0] integ, next_integ;
  logic signed [15:0] err_now, next_err_now;
  logic signed [15:0] err_prev, next_err_prev;
  logic signed [AW-1:0] sum;
  logic fifo_in_valid, next_fifo_in_valid;
  logic fifo_in_ready;
  pvc_pkg::pvc_result_s fifo_in, next_fifo_in, fifo_out;
  logic fifo_out_valid;
  logic [CW-1:0] gap, next_gap;
  logic next_overrun;
  // One multiplier shared by all three products keeps the area small; four cycles per update.
  logic signed [15:0] mul_a, mul_b;
  logic signed [31:0] prod;
  always_comb begin
    mul_a = err_now;
    mul_b = KI;
    case (state)
      pvc_pkg::PVC_PROP: mul_b = KP;
      pvc_pkg::PVC_INT2: mul_a = err_prev;
      default: mul_b = KI;
    endcase
    prod = mul_a * mul_b;
  end
  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    next_state = state;
    next_acc_p = acc_p;
    next_integ = integ;
    next_err_now = err_now;
    next_err_prev = err_prev;
    next_fifo_in_valid = fifo_in_valid && !fifo_in_ready;
    next_fifo_in = fifo_in;
    sum = integ + acc_p;
    next_gap = (gap == CW'(pvc_pkg::PERIOD_CYCLES)) ? gap : gap + CW'(1);
    next_overrun = 1'b0;
    case (state)
      pvc_pkg::PVC_IDLE: begin
        if (sample_valid && sample_ready) begin
          next_err_now = sample.err;
          next_state = pvc_pkg::PVC_PROP;
          next_overrun = (gap != CW'(pvc_pkg::PERIOD_CYCLES));
          // Counting from one makes a gap of exactly one period count as on time.
          next_gap = CW'(1);
        end
      end
      pvc_pkg::PVC_PROP: begin
        next_acc_p = AW'(prod) >>> SH_P;
        next_state = pvc_pkg::PVC_INT1;
      end
      pvc_pkg::PVC_INT1: begin
        // The integral keeps every fraction bit of the product so small errors still build up.
        next_integ = integ + AW'(prod);
        next_state = pvc_pkg::PVC_INT2;
      end
      pvc_pkg::PVC_INT2: begin
        next_integ = integ + AW'(prod);
        next_err_prev = err_now;
        next_state = pvc_pkg::PVC_IDLE;
        sum = ((integ + AW'(prod)) >>> SH_I) + acc_p;
        next_fifo_in_valid = 1'b1;
        next_fifo_in.sat = (sum > OUT_MAX) || (sum < OUT_MIN);
        if (sum > OUT_MAX) begin
          next_fifo_in.ctrl = 16'sh7FFF;
        end else if (sum < OUT_MIN) begin
          next_fifo_in.ctrl = 16'sh8000;
        end else begin
          next_fifo_in.ctrl = sum[15:0];
        end
      end
      default: next_state = pvc_pkg::PVC_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= pvc_pkg::PVC_IDLE;
      acc_p <= '0;
      integ <= '0;
      err_now <= '0;
      err_prev <= '0;
      fifo_in_valid <= 1'b0;
      fifo_in <= '0;
      gap <= CW'(pvc_pkg::PERIOD_CYCLES);
      update_overrun <= 1'b0;
    end else begin
      state <= next_state;
      acc_p <= next_acc_p;
      integ <= next_integ;
      err_now <= next_err_now;
      err_prev <= next_err_prev;
      fifo_in_valid <= next_fifo_in_valid;
      fifo_in <= next_fifo_in;
      gap <= next_gap;
      update_overrun <= next_overrun;
    end
  end
  // ==========================================================================
  // Output stream
  // ==========================================================================
  // A new sample waits while a result is still pending, so no update is ever dropped.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sample_ready <= 1'b0;
      compensator_output <= '0;
      compensator_output_valid <= 1'b0;
    end else begin
      sample_ready <= (next_state == pvc_pkg::PVC_IDLE) && !next_fifo_in_valid
        && !(sample_ready && sample_valid);
      if (!compensator_output_valid || compensator_output_ready) begin
        compensator_output <= fifo_out;
        compensator_output_valid <= fifo_out_valid;
      end
    end
  end
  pvc_fifo #(
    .WIDTH($bits(pvc_pkg::pvc_result_s)),
    .DEPTH(pvc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_data(fifo_in),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(!compensator_output_valid || compensator_output_ready)
  );
endmodule

// ==========================================================================
// Result FIFO
// ==========================================================================
// Synchronous FIFO with valid/ready on both sides for the compensator result stream.
// Assumes a single clock and a synchronous active-high reset.
module pvc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // A depth that is not a power of two would break the wrap bit of the pointers.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("pvc_fifo depth must be a power of two of at least 2");
  end
  // ==========================================================================
  // Storage and pointers
  // ==========================================================================
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop;
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = wr_ptr + (AW+1)'(push);
    next_rd_ptr = rd_ptr + (AW+1)'(pop);
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_comb begin
    in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    out_valid = (wr_ptr != rd_ptr);
    out_data = mem[rd_ptr[AW-1:0]];
  end
endmodule

/* File: bench/pvc_pi_voltage_compensator_properties.sv */
// Checker for the PI compensator ports, bound into the top module.
// Assumes one clock mclk and synchronous reset sys_rst.
module pvc_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire pvc_pkg::pvc_sample_s sample,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire pvc_pkg::pvc_result_s compensator_output,
  input wire logic compensator_output_valid,
  input wire logic compensator_output_ready,
  input wire logic update_overrun
);
  // ==========================================================================
  // Helper counters
  // ==========================================================================
  logic [10:0] gap, next_gap;
  logic seen, next_seen;
  logic [4:0] pend, next_pend;
  wire take = sample_valid && sample_ready;
  wire give = compensator_output_valid && compensator_output_ready;
  always_comb begin
    next_gap = sys_rst ? 11'h000 : (take ? 11'h000 : gap + 11'(gap != 11'h7FF));
    next_seen = !sys_rst && (seen || take);
    next_pend = sys_rst ? 5'h00 : pend + 5'(take) - 5'(give);
  end
  always_ff @(posedge mclk) begin
    gap <= next_gap;
    seen <= next_seen;
    pend <= next_pend;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_take; sample_valid && sample_ready; endsequence
  sequence s_busy; !sample_ready [*3]; endsequence
  property p_busy; s_take |=> s_busy; endproperty
  a_busy: assert property (p_busy) else $error("sample taken while busy");
  property p_hold;
    compensator_output_valid && !compensator_output_ready |=>
      compensator_output_valid && $stable(compensator_output);
  endproperty
  a_hold: assert property (p_hold) else $error("result dropped");
  property p_first; $fell(sys_rst) |-> !compensator_output_valid ##1 sample_ready; endproperty
  a_first: assert property (p_first) else $error("bad state after reset");
  property p_fast; s_take ##0 (seen && gap < 11'd1000) |=> update_overrun; endproperty
  a_fast: assert property (p_fast) else $error("overrun not flagged");
  property p_slow; s_take ##0 (gap > 11'd1400) |=> !update_overrun; endproperty
  a_slow: assert property (p_slow) else $error("false overrun");
  property p_early;
    s_take ##0 (seen && gap == 11'(pvc_pkg::PERIOD_CYCLES - 2)) |=> update_overrun;
  endproperty
  a_early: assert property (p_early) else $error("overrun missed one cycle early");
  property p_ontime;
    s_take ##0 (gap == 11'(pvc_pkg::PERIOD_CYCLES - 1)) |=> !update_overrun;
  endproperty
  a_ontime: assert property (p_ontime) else $error("overrun on a full period");
  property p_pulse; update_overrun |=> !update_overrun; endproperty
  a_pulse: assert property (p_pulse) else $error("overrun too long");
  property p_sat;
    compensator_output_valid && compensator_output.sat |->
      compensator_output.ctrl == 16'sh7FFF || compensator_output.ctrl == 16'sh8000;
  endproperty
  a_sat: assert property (p_sat) else $error("clip value wrong");
  property p_pend; compensator_output_valid |-> pend != 5'h00; endproperty
  a_pend: assert property (p_pend) else $error("result without sample");
endmodule
bind pvc_pi_voltage_compensator pvc_checker i_pvc_checker (.mclk(mclk), .sys_rst(sys_rst),
  .sample(sample), .sample_valid(sample_valid), .sample_ready(sample_ready),
  .compensator_output(compensator_output), .compensator_output_valid(compensator_output_valid),
  .compensator_output_ready(compensator_output_ready), .update_overrun(update_overrun));

/* File: bench/pvc_partner.sv */
// Model of the voltage sampler and the peak current reference stage.
// Assumes the bench drives stall; results are queued in arrival order.
module pvc_partner (
  input wire logic mclk,
  input wire logic stall,
  input wire logic sample_ready,
  output pvc_pkg::pvc_sample_s sample,
  output logic sample_valid,
  input wire pvc_pkg::pvc_result_s res,
  input wire logic res_valid,
  output logic res_ready
);
  // ==========================================================================
  // Both sides
  // ==========================================================================
  pvc_pkg::pvc_result_s got[$];
  initial begin
    sample = '0;
    sample_valid = 1'b0;
  end
  assign res_ready = !stall;
  always @(posedge mclk) begin
    if (res_valid && res_ready) got.push_back(res);
  end
  // Released data is inverted so a stale sample can never pass for a fresh one.
  task automatic send(input logic [15:0] e);
    @(negedge mclk);
    sample.err = e;
    sample_valid = 1'b1;
    do @(posedge mclk); while (sample_ready !== 1'b1);
    @(negedge mclk);
    sample_valid = 1'b0;
    sample.err = ~e;
  endtask
endmodule

/* File: bench/tb_pvc_pi_voltage_compensator.sv */
// Self-checking bench for the PI compensator with its far-side model.
// Assumes default gains and a 100 MHz clock; inputs change on falling edges.
module tb_pvc_pi_voltage_compensator;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Wiring
  // ==========================================================================
  logic mclk, sys_rst, stall, sample_valid, sample_ready, res_valid, res_ready, ovf;
  pvc_pkg::pvc_sample_s sample;
  pvc_pkg::pvc_result_s res;
  int num_errors = 0;
  int checks = 0;
  int ovr = 0;
  // Each row is the error sample then the expected {ctrl, sat}.
  logic [32:0] rows [6] = '{{16'h0100, 17'h02924}, {16'h0100, 17'h03170},
    {16'hFF00, 17'h1E770}, {16'hFF00, 17'h1DF24}, {16'h7FFF, 17'h0FFFF},
    {16'h8000, 17'h10001}};
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  pvc_pi_voltage_compensator i_pvc_pi_voltage_compensator (.mclk(mclk), .sys_rst(sys_rst),
    .sample(sample), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .compensator_output(res), .compensator_output_valid(res_valid),
    .compensator_output_ready(res_ready), .update_overrun(ovf));
  pvc_partner i_pvc_partner (.mclk(mclk), .stall(stall), .sample_ready(sample_ready),
    .sample(sample), .sample_valid(sample_valid), .res(res), .res_valid(res_valid),
    .res_ready(res_ready));
  always @(posedge mclk) begin
    if (ovf === 1'b1) ovr++;
  end
  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
  endtask
  // The limit covers the spaced rows plus the stalled burst with a wide margin.
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    stop_test();
  end
  initial begin
    stall = 1'b0;
    sys_rst = 1'b1;
    do_reset();
    foreach (rows[i]) begin
      i_pvc_partner.send(rows[i][32:17]);
      repeat (1400) @(negedge mclk);
      check("ctrl", i_pvc_partner.got[i], rows[i][16:0]);
    end
    check("spaced_overrun", 17'(ovr), 17'h00000);
    do_reset();
    i_pvc_partner.got.delete();
    i_pvc_partner.send(16'h0100);
    repeat (1400) @(negedge mclk);
    check("after_reset", i_pvc_partner.got[0], 17'h02924);
    ovr = 0;
    stall = 1'b1;
    fork
      repeat (11) i_pvc_partner.send(16'h0000);
    join_none
    repeat (300) @(negedge mclk);
    check("held", 17'(i_pvc_partner.got.size()), 17'h00001);
    check("refused", 17'(sample_ready), 17'h00000);
    stall = 1'b0;
    wait fork;
    repeat (100) @(negedge mclk);
    check("count", 17'(i_pvc_partner.got.size()), 17'h0000C);
    check("retained", i_pvc_partner.got[11], 17'h0084A);
    check("burst_overrun", 17'(ovr >= 10), 17'h00001);
    i_pvc_partner.send(16'h0000);
    repeat (4) @(negedge mclk);
    ovr = 0;
    repeat (pvc_pkg::PERIOD_CYCLES - 7) @(negedge mclk);
    i_pvc_partner.send(16'h0000);
    repeat (10) @(negedge mclk);
    check("early_overrun", 17'(ovr), 17'h00001);
    repeat (pvc_pkg::PERIOD_CYCLES - 12) @(negedge mclk);
    i_pvc_partner.send(16'h0000);
    repeat (10) @(negedge mclk);
    check("ontime_overrun", 17'(ovr), 17'h00001);
    stop_test();
  end
endmodule
